// *** verilog/fse_ctrl.sv ***
// Purpose: Serial NOR command sequencer for block/array erase and suspend
// Assumes: Serial pins are asynchronous; sclk much slower than clk
// Notes:   The array itself sits outside; this block issues erase requests
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module fse_ctrl #(
  parameter logic [31:0] BE_CYC = fse_pkg::BE_CYC,
  parameter logic [31:0] CE_CYC = fse_pkg::CE_CYC,
  parameter logic [31:0] PP_CYC = fse_pkg::PP_CYC,
  parameter logic [31:0] SL_CYC = fse_pkg::SL_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              sclk,
  input  wire logic              chip_select_n,
  input  wire logic [3:0]        io_in,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  output logic                   op_in_progress,
  output fse_pkg::fse_stat_t     status,
  output logic                   arr_erase_go,
  output logic                   arr_erase_all,
  output logic [15:0]            arr_erase_blk,
  output logic                   cmd_ok,
  output logic                   cmd_refused,
  output logic [7:0]             cmd_op
);
  // ----------------------------------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------------------------------
  logic [5:0] s1_r, s2_r;
  logic       sclk_d_r, cs_d_r;
  wire        sclk_s = s2_r[5];
  wire        cs_s   = s2_r[4];
  wire [3:0]  io_s   = s2_r[3:0];
  wire        sclk_rise = sclk_s & ~sclk_d_r;
  wire        cs_rise   = cs_s & ~cs_d_r;
  wire        cs_fall   = ~cs_s & cs_d_r;
  // Two flops per pin, edge detect on the second
  always_ff @(posedge clk) begin
    s1_r     <= {sclk, chip_select_n, io_in};
    s2_r     <= s1_r;
    sclk_d_r <= rst ? 1'b0 : sclk_s;
    cs_d_r   <= rst ? 1'b1 : cs_s;
  end
  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [2:0]  ctrl_r;
  logic [31:0] prot_r;
  wire         als   = ctrl_r[fse_pkg::CTRL_ALS];
  wire         quad  = ctrl_r[fse_pkg::CTRL_QM];
  wire         p_en  = ctrl_r[fse_pkg::CTRL_PE];
  wire         wr_ctrl = reg_wr && reg_addr == fse_pkg::REG_CTRL;
  wire         wr_prot = reg_wr && reg_addr == fse_pkg::REG_PROT;
  wire         wr_stat = reg_wr && reg_addr == fse_pkg::REG_STAT;
  // Lock range is writable at any time, also in erase suspend
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= fse_pkg::CTRL_RST;
      prot_r <= fse_pkg::PROT_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= reg_wdata[2:0];
      if (wr_prot) prot_r <= reg_wdata;
    end
  end
  // ----------------------------------------------------------------
  // Serial shifter
  // ----------------------------------------------------------------
  logic [39:0] sh_r;
  logic [8:0]  cnt_r;
  logic [7:0]  op_r;
  logic [31:0] adr_r;
  // Total opcode plus address length for an opcode
  function automatic logic [8:0] aend(input logic [7:0] op, input logic w);
    if (op == fse_pkg::OP_BLK_W || op == fse_pkg::OP_PP_W ||
        op == fse_pkg::OP_QPP_W || op == fse_pkg::OP_RD_W || w)
      return fse_pkg::LEN_A4;
    return fse_pkg::LEN_A3;
  endfunction
  wire [8:0] a_len = aend(op_r, als);
  wire [8:0] step  = quad ? 9'h004 : 9'h001;
  // Quad mode takes four lines per clock, else line 0
  always_ff @(posedge clk) begin
    if (rst || cs_fall) begin
      cnt_r <= '0;
    end else if (sclk_rise && !cs_s && cnt_r < fse_pkg::LEN_MAX) begin
      sh_r  <= quad ? {sh_r[35:0], io_s} : {sh_r[38:0], io_s[0]};
      cnt_r <= cnt_r + step;
    end
  end
  // Latch opcode and address as their last bit lands; cleared so outputs start defined
  always_ff @(posedge clk) begin
    if (rst) begin
      op_r  <= '0;
      adr_r <= '0;
    end else begin
      if (cnt_r == fse_pkg::LEN_OP) op_r <= sh_r[7:0];
      if (cnt_r == a_len) adr_r <= (a_len == fse_pkg::LEN_A4) ? sh_r[31:0]
                                                             : {8'h00, sh_r[23:0]};
    end
  end
  // ----------------------------------------------------------------
  // Command decode at chip select rise
  // ----------------------------------------------------------------
  logic e_run_r, e_chip_r, p_run_r, e_susp_r, p_susp_r, wl_r, ef_r, pf_r;
  logic [31:0] e_cnt_r, p_cnt_r, sl_cnt_r;
  logic [15:0] e_blk_r;
  logic [23:0] p_page_r;
  wire [15:0] blk    = adr_r[31:fse_pkg::BLK_LSB];
  wire        len8   = cnt_r == fse_pkg::LEN_OP;
  wire        len_a  = cnt_r == a_len;
  wire        len_pp = cnt_r >= a_len + fse_pkg::LEN_BYTE && cnt_r[2:0] == 3'h0;
  wire        busy   = e_run_r | p_run_r;
  wire        any_s  = e_susp_r | p_susp_r;
  wire        is_blk  = op_r == fse_pkg::OP_BLK || op_r == fse_pkg::OP_BLK_W;
  wire        is_chip = op_r == fse_pkg::OP_CHIP_A || op_r == fse_pkg::OP_CHIP_B;
  wire        is_pp   = op_r == fse_pkg::OP_PP || op_r == fse_pkg::OP_PP_W ||
                        op_r == fse_pkg::OP_QPP || op_r == fse_pkg::OP_QPP_W;
  wire        is_rd   = op_r == fse_pkg::OP_RD || op_r == fse_pkg::OP_RD_W;
  wire        is_st   = op_r == fse_pkg::OP_ST1 || op_r == fse_pkg::OP_ANY_RD ||
                        op_r == fse_pkg::OP_ST2 || op_r == fse_pkg::OP_CFG1;
  wire        blk_prot = p_en && blk >= prot_r[15:0] && blk <= prot_r[31:16];
  wire        in_e_s  = e_susp_r && blk == e_blk_r;
  wire        in_p_s  = p_susp_r && adr_r[31:fse_pkg::PAGE_LSB] == p_page_r;
  // Frame must end exactly after its last address or opcode bit, except program, which ends on a data byte boundary
  wire blk_cmd  = cs_rise && is_blk && len_a && wl_r && !busy && !any_s;
  wire blk_go   = blk_cmd && !blk_prot;
  wire blk_bad  = blk_cmd && blk_prot;
  wire chip_cmd = cs_rise && is_chip && len8 && wl_r && !busy && !any_s;
  wire chip_go  = chip_cmd && !p_en;
  wire chip_bad = chip_cmd && p_en;
  // Program only from idle or inside an erase suspend
  wire pp_cmd   = cs_rise && is_pp && len_pp && wl_r && !busy && !p_susp_r;
  wire pp_bad   = pp_cmd && (in_e_s || blk_prot);
  wire pp_go    = pp_cmd && !pp_bad;
  wire rd_ok    = cs_rise && is_rd && len_a && !busy && !in_e_s && !in_p_s;
  wire st_ok    = cs_rise && is_st && len8;
  wire susp_cmd = cs_rise && op_r == fse_pkg::OP_SUSP && len8;
  wire susp_go  = susp_cmd && !any_s && sl_cnt_r == '0 &&
                  (p_run_r || (e_run_r && !e_chip_r));
  wire res_cmd  = cs_rise && op_r == fse_pkg::OP_RESUME && len8 && !busy;
  wire wl_set   = cs_rise && op_r == fse_pkg::OP_WL_SET && len8;
  wire wl_clr   = cs_rise && op_r == fse_pkg::OP_WL_CLR && len8;
  wire clr_st   = cs_rise && op_r == fse_pkg::OP_CLR_ST && len8;
  // Known opcodes, so a wrong-length frame of one still reports a refusal
  wire known    = is_blk || is_chip || is_pp || is_rd || is_st ||
                  op_r == fse_pkg::OP_WL_SET || op_r == fse_pkg::OP_WL_CLR ||
                  op_r == fse_pkg::OP_CLR_ST || op_r == fse_pkg::OP_SUSP ||
                  op_r == fse_pkg::OP_RESUME;
  // Any frame of eight bits or more not taken above is refused
  wire refuse   = cs_rise && cnt_r >= fse_pkg::LEN_OP && !blk_go && !blk_bad &&
                  !chip_go && !chip_bad && !pp_go && !pp_bad && !rd_ok && !st_ok &&
                  !wl_set && !wl_clr && !clr_st && !susp_go && !res_cmd;
  // Counters end on one; zero means nothing pending
  wire sl_done  = sl_cnt_r == 32'h0000_0001;
  wire e_end    = e_run_r && e_cnt_r == 32'h0000_0001;
  wire p_end    = p_run_r && p_cnt_r == 32'h0000_0001;
  // ----------------------------------------------------------------
  // Erase engine
  // ----------------------------------------------------------------
  // Suspended erase keeps its remaining count; resume carries on from it
  always_ff @(posedge clk) begin
    if (rst) begin
      e_run_r  <= 1'b0;
      e_chip_r <= 1'b0;
      e_susp_r <= 1'b0;
      e_cnt_r  <= '0;
      e_blk_r  <= '0;
    end else if (blk_go || chip_go) begin
      e_run_r  <= 1'b1;
      e_chip_r <= chip_go;
      e_cnt_r  <= chip_go ? CE_CYC : BE_CYC;
      e_blk_r  <= blk;
    end else if (sl_done && e_run_r && !p_run_r && !e_end) begin
      e_run_r  <= 1'b0;
      e_susp_r <= 1'b1;
    end else if (res_cmd && e_susp_r && !p_susp_r) begin
      e_run_r  <= 1'b1;
      e_susp_r <= 1'b0;
    end else if (e_run_r) begin
      e_run_r  <= !e_end;
      e_cnt_r  <= e_cnt_r - 32'h0000_0001;
    end
  end
  // ----------------------------------------------------------------
  // Program engine and suspend latency
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      p_run_r  <= 1'b0;
      p_susp_r <= 1'b0;
      p_cnt_r  <= '0;
      p_page_r <= '0;
    end else if (pp_go) begin
      p_run_r  <= 1'b1;
      p_cnt_r  <= PP_CYC;
      p_page_r <= adr_r[31:fse_pkg::PAGE_LSB];
    end else if (sl_done && p_run_r && !p_end) begin
      p_run_r  <= 1'b0;
      p_susp_r <= 1'b1;
    end else if (res_cmd && p_susp_r) begin
      p_run_r  <= 1'b1;
      p_susp_r <= 1'b0;
    end else if (p_run_r) begin
      p_run_r  <= !p_end;
      p_cnt_r  <= p_cnt_r - 32'h0000_0001;
    end
  end
  // Latency count; suspend lands as it expires
  always_ff @(posedge clk) begin
    if (rst || !busy) sl_cnt_r <= '0;
    else if (susp_go) sl_cnt_r <= SL_CYC;
    else if (sl_cnt_r != '0) sl_cnt_r <= sl_cnt_r - 32'h0000_0001;
  end
  // ----------------------------------------------------------------
  // Latch and fault flags
  // ----------------------------------------------------------------
  // Faults clear by clear-status frame or by writing ones to the status word
  wire clr_ef = clr_st || (wr_stat && reg_wdata[fse_pkg::STAT_EF]);
  wire clr_pf = clr_st || (wr_stat && reg_wdata[fse_pkg::STAT_PF]);
  // Set beats clear on the same edge
  always_ff @(posedge clk) begin
    if (rst) begin
      wl_r <= 1'b0;
      ef_r <= 1'b0;
      pf_r <= 1'b0;
    end else begin
      if (wl_set) wl_r <= 1'b1;
      else if (wl_clr || blk_cmd || chip_cmd || pp_cmd) wl_r <= 1'b0;
      ef_r <= blk_bad || chip_bad || (ef_r && !clr_ef);
      pf_r <= pp_bad || (pf_r && !clr_pf);
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire fse_pkg::fse_stat_t st_nxt = '{erase_susp: e_susp_r, prog_susp: p_susp_r,
                                      prog_fault: pf_r, erase_fault: ef_r,
                                      write_latch: wl_r, busy: busy};
  wire [31:0] rd_nxt = (reg_addr == fse_pkg::REG_CTRL) ? {29'h0, ctrl_r} :
                       (reg_addr == fse_pkg::REG_PROT) ? prot_r :
                       (reg_addr == fse_pkg::REG_STAT) ? {26'h0, st_nxt} : 32'h0;
  // Everything leaves through a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata      <= '0;
      op_in_progress <= 1'b0;
      status         <= fse_pkg::STAT_RST;
      arr_erase_go   <= 1'b0;
      arr_erase_all  <= 1'b0;
      arr_erase_blk  <= '0;
      cmd_ok         <= 1'b0;
      cmd_refused    <= 1'b0;
      cmd_op         <= '0;
    end else begin
      reg_rdata      <= reg_rd ? rd_nxt : 32'h0;
      op_in_progress <= busy;
      status         <= st_nxt;
      arr_erase_go   <= blk_go || chip_go;
      arr_erase_all  <= chip_go;
      arr_erase_blk  <= blk;
      cmd_ok         <= rd_ok || st_ok;
      cmd_refused    <= refuse && known;
      cmd_op         <= cs_rise ? op_r : cmd_op;
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Decode pulses and engine state against the output flops
  chk_blk_starts: assert property (@(posedge clk) disable iff (rst)
    blk_go |=> e_run_r ##1 op_in_progress) else $error("block erase did not start");
  chk_blk_latch: assert property (@(posedge clk) disable iff (rst)
    $rose(arr_erase_go) |-> $past(wl_r, 2)) else $error("erase without latch");
  chk_prot_fault: assert property (@(posedge clk) disable iff (rst)
    blk_bad |=> ef_r && !e_run_r) else $error("protected block not refused");
  chk_chip_prot: assert property (@(posedge clk) disable iff (rst)
    chip_cmd && p_en |=> ef_r && !arr_erase_go ##1 !arr_erase_go)
    else $error("protected array erase not refused");
  chk_chip_nosusp: assert property (@(posedge clk) disable iff (rst)
    e_chip_r && e_run_r |-> sl_cnt_r == '0) else $error("array erase suspended");
  chk_susp_lands: assert property (@(posedge clk) disable iff (rst)
    $rose(e_susp_r) || $rose(p_susp_r) |-> $past(sl_cnt_r) == 32'h0000_0001)
    else $error("suspend flag without latency expiry");
  chk_susp_ignore: assert property (@(posedge clk) disable iff (rst)
    susp_cmd && any_s |=> sl_cnt_r == '0) else $error("nested suspend taken");
  chk_resume_run: assert property (@(posedge clk) disable iff (rst)
    res_cmd && p_susp_r |=> p_run_r && !p_susp_r) else $error("resume failed");
  chk_read_block: assert property (@(posedge clk) disable iff (rst)
    cs_rise && is_rd && len_a && in_e_s |=> cmd_refused && !cmd_ok)
    else $error("read of suspended block allowed");
  chk_pp_fault: assert property (@(posedge clk) disable iff (rst)
    pp_cmd && in_e_s |=> pf_r && !p_run_r) else $error("program in block not failed");
  chk_busy_out: assert property (@(posedge clk) disable iff (rst)
    op_in_progress == $past(busy)) else $error("busy output lags");
  chk_latch_need: assert property (@(posedge clk) disable iff (rst)
    cs_rise && is_blk && !wl_r |=> !arr_erase_go) else $error("erase without latch taken");
  chk_chip_all: assert property (@(posedge clk) disable iff (rst)
    chip_go |=> arr_erase_go && arr_erase_all) else $error("array erase not issued");
  chk_resume_erase: assert property (@(posedge clk) disable iff (rst)
    res_cmd && e_susp_r && !p_susp_r |=> e_run_r && !e_susp_r)
    else $error("erase resume blocked");
  chk_psusp_only: assert property (@(posedge clk) disable iff (rst)
    cs_rise && p_susp_r && (is_blk || is_chip || is_pp) && cnt_r >= fse_pkg::LEN_OP
    |=> cmd_refused && !arr_erase_go) else $error("write taken in program suspend");
  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  cov_blk_done: cover property (@(posedge clk) disable iff (rst) $fell(e_run_r) && !e_susp_r);
  cov_e_susp: cover property (@(posedge clk) disable iff (rst) $rose(e_susp_r));
  cov_pp_in_es: cover property (@(posedge clk) disable iff (rst) pp_go && e_susp_r);
  cov_chip: cover property (@(posedge clk) disable iff (rst) chip_go);
  cov_p_susp: cover property (@(posedge clk) disable iff (rst) $rose(p_susp_r));
endmodule

// *** verilog/fse_pkg.sv ***
// Purpose: Shared constants and types for the flash erase/suspend sequencer
// Assumes: 125 MHz system clock
// Notes:   Times in ns, cycle counts derived from them
package fse_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_NS   = 8;
  localparam int T_BE_NS  = 1_000_000;  // Block erase time
  localparam int T_CE_NS  = 8_000_000;  // Whole array erase time
  localparam int T_PP_NS  = 400_000;    // Page program time
  localparam int T_SL_NS  = 40_000;     // Longest suspend latency
  localparam logic [31:0] BE_CYC = 32'((T_BE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [31:0] CE_CYC = 32'((T_CE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [31:0] PP_CYC = 32'((T_PP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [31:0] SL_CYC = 32'(T_SL_NS / CLK_NS);
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_BLK     = 8'hD8;
  localparam logic [7:0] OP_BLK_W   = 8'hDC;
  localparam logic [7:0] OP_CHIP_A  = 8'h60;
  localparam logic [7:0] OP_CHIP_B  = 8'hC7;
  localparam logic [7:0] OP_SUSP    = 8'h75;
  localparam logic [7:0] OP_RESUME  = 8'h7A;
  localparam logic [7:0] OP_WL_SET  = 8'h06;
  localparam logic [7:0] OP_WL_CLR  = 8'h04;
  localparam logic [7:0] OP_CLR_ST  = 8'h30;
  localparam logic [7:0] OP_RD      = 8'h03;
  localparam logic [7:0] OP_RD_W    = 8'h13;
  localparam logic [7:0] OP_PP      = 8'h02;
  localparam logic [7:0] OP_PP_W    = 8'h12;
  localparam logic [7:0] OP_QPP     = 8'h32;
  localparam logic [7:0] OP_QPP_W   = 8'h34;
  localparam logic [7:0] OP_ST1     = 8'h05;
  localparam logic [7:0] OP_ANY_RD  = 8'h65;
  localparam logic [7:0] OP_ST2     = 8'h07;
  localparam logic [7:0] OP_CFG1    = 8'h35;
  // ----------------------------------------------------------------
  // Frame lengths in bits
  // ----------------------------------------------------------------
  localparam logic [8:0] LEN_OP     = 9'h008;
  localparam logic [8:0] LEN_A3     = 9'h020;
  localparam logic [8:0] LEN_A4     = 9'h028;
  localparam logic [8:0] LEN_BYTE   = 9'h008;
  localparam logic [8:0] LEN_MAX    = 9'h1FC;
  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_PROT   = 8'h04;
  localparam logic [7:0] REG_STAT   = 8'h08;
  localparam int CTRL_ALS = 0;  // addr_len_select
  localparam int CTRL_QM  = 1;  // quad_cmd_mode
  localparam int CTRL_PE  = 2;  // Protection range enable
  localparam logic [2:0]  CTRL_RST = 3'h0;
  localparam logic [31:0] PROT_RST = 32'h0000_0000;
  localparam int BLK_LSB  = 16;  // Block number starts above 64 KB
  localparam int PAGE_LSB = 8;
  // Status fields, high bit first in the status word
  typedef struct packed {
    logic erase_susp;
    logic prog_susp;
    logic prog_fault;
    logic erase_fault;
    logic write_latch;
    logic busy;
  } fse_stat_t;
  localparam int STAT_PF = 3;
  localparam int STAT_EF = 2;
  localparam fse_stat_t STAT_RST = '0;
endpackage

// *** dv/fse_host_model.sv ***
// Purpose: Host controller model driving the serial flash pins
// Assumes: Four clk per sclk phase, giving the 64 ns link clock
// Notes:   The bench sends frames by calling frame()
`timescale 1ns/10ps
module fse_host_model (
  input  wire logic       clk,
  output logic            sclk,
  output logic            chip_select_n,
  output logic [3:0]      io
);
  // Idle pins: clock low, frame closed
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    io = 4'h5;
  end
  // ----------------------------------------------------------------
  // Frame sender
  // ----------------------------------------------------------------
  // Send n bits MSB first, one bit or one nibble per sclk
  task automatic frame(input logic [39:0] d, input int n, input logic q);
    int i;
    @(posedge clk) chip_select_n <= 1'b0;
    for (i = (q ? n / 4 : n) - 1; i >= 0; i--) begin
      io <= q ? d[4*i +: 4] : {3'h0, d[i]};
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    chip_select_n <= 1'b1;
    io <= ~io;
    repeat (8) @(posedge clk);
  endtask
endmodule

// *** dv/spi_flash_erase_suspend_ctrl_bench.sv ***
// Purpose: Self-checking bench for the erase and suspend sequencer
// Assumes: Shortened erase times; host model drives the serial pins
// Notes:   Array pulses and command pulses are counted by a monitor
`timescale 1ns/10ps
module spi_flash_erase_suspend_ctrl_bench;
  logic               clk, rst, reg_wr, reg_rd, q_r, all_r;
  logic [7:0]         reg_addr, cmd_op;
  logic [31:0]        reg_wdata, reg_rdata;
  logic               sclk, chip_select_n, op_in_progress, arr_erase_go, arr_erase_all;
  logic               cmd_ok, cmd_refused;
  logic [3:0]         io;
  logic [15:0]        arr_erase_blk, blk_r;
  fse_pkg::fse_stat_t status;
  int                 err_count, tests_run, cyc, go_n, ref_n, ok_n;
  fse_host_model host (.clk(clk), .sclk(sclk), .chip_select_n(chip_select_n), .io(io));
  fse_ctrl #(.BE_CYC(32'h0000_0190), .CE_CYC(32'h0000_0258), .PP_CYC(32'h0000_00C8),
    .SL_CYC(32'h0000_000A)) dut (.clk(clk), .rst(rst), .sclk(sclk),
    .chip_select_n(chip_select_n), .io_in(io), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_in_progress(op_in_progress),
    .status(status), .arr_erase_go(arr_erase_go), .arr_erase_all(arr_erase_all),
    .arr_erase_blk(arr_erase_blk), .cmd_ok(cmd_ok), .cmd_refused(cmd_refused), .cmd_op(cmd_op));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic fr(input logic [39:0] d, input int n);
    host.frame(d, n, q_r);
  endtask
  task automatic wl;
    fr(40'h00_0000_0006, 8);
  endtask
  task automatic clr;
    go_n = 0;
    ref_n = 0;
    ok_n = 0;
  endtask
  task automatic idle;
    for (int i = 0; i < 800 && op_in_progress !== 1'b0; i++) @(posedge clk);
    chk(32'(op_in_progress), 0);
  endtask
  task automatic finish_test;
    $display("tests %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_erase;
    clr;
    rdchk(fse_pkg::REG_STAT, 32'h0000_0000);
    fr(40'h00_D801_0000, 32);
    chk(go_n, 0);
    wl;
    fr(40'h00_D812_3456, 32);
    chk(go_n, 1);
    chk(32'(blk_r), 32'h0000_0012);
    chk(32'(op_in_progress), 1);
    idle;
    wr(fse_pkg::REG_CTRL, 32'h0000_0001);
    wl;
    fr(40'hD8_ABCD_1234, 40);
    chk(32'(blk_r), 32'h0000_ABCD);
    idle;
    wr(fse_pkg::REG_CTRL, 32'h0000_0000);
    wl;
    fr(40'hDC_5678_9ABC, 40);
    chk(32'(blk_r), 32'h0000_5678);
    idle;
    wl;
    fr(40'h01_B000_0000, 33);
    fr(40'h00_0000_018E, 9);
    chk(go_n, 3);
    fr(40'h00_0000_0004, 8);
    $display("erase test done");
  endtask
  task automatic t_prot;
    clr;
    wr(fse_pkg::REG_PROT, 32'h0006_0005);
    wr(fse_pkg::REG_CTRL, 32'h0000_0004);
    wl;
    fr(40'h00_D806_FFFF, 32);
    chk(go_n, 0);
    rdchk(fse_pkg::REG_STAT, 32'h0000_0004);
    wr(fse_pkg::REG_STAT, 32'h0000_0004);
    wl;
    fr(40'h00_D804_FFFF, 32);
    chk(32'(blk_r), 32'h0000_0004);
    idle;
    wl;
    fr(40'h00_0000_0060, 8);
    chk(go_n, 1);
    rdchk(fse_pkg::REG_STAT, 32'h0000_0004);
    wr(fse_pkg::REG_STAT, 32'h0000_0004);
    wr(fse_pkg::REG_CTRL, 32'h0000_0002);
    q_r = 1'b1;
    wl;
    fr(40'h00_0000_00C7, 8);
    chk({go_n[30:0], all_r}, 32'h0000_0005);
    idle;
    wl;
    fr(40'hDC_0003_0000, 40);
    chk(32'(blk_r), 32'h0000_0003);
    idle;
    wr(fse_pkg::REG_CTRL, 32'h0000_0000);
    q_r = 1'b0;
    $display("protect and quad test done");
  endtask
  task automatic t_susp;
    clr;
    wl;
    fr(40'h00_D820_0000, 32);
    fr(40'h00_0000_0075, 8);
    repeat (12) @(posedge clk);
    chk(32'(op_in_progress), 0);
    rdchk(fse_pkg::REG_STAT, 32'h0000_0020);
    chk(32'(status), 32'h0000_0020);
    fr(40'h00_0000_0075, 8);
    chk(ref_n, 1);
    fr(40'h00_0330_0000, 32);
    fr(40'h00_0000_0005, 8);
    fr(40'h00_0000_0007, 8);
    fr(40'h00_0000_0035, 8);
    chk(32'(cmd_op), 32'h0000_0035);
    fr(40'h00_0320_0000, 32);
    chk(ok_n, 4);
    chk(ref_n, 2);
    wl;
    fr(40'h02_2000_10A5, 40);
    rdchk(fse_pkg::REG_STAT, 32'h0000_0028);
    wr(fse_pkg::REG_STAT, 32'h0000_0008);
    wr(fse_pkg::REG_PROT, 32'h0020_0020);
    wr(fse_pkg::REG_CTRL, 32'h0000_0004);
    rdchk(fse_pkg::REG_PROT, 32'h0020_0020);
    fr(40'h00_0000_007A, 8);
    chk(32'(op_in_progress), 1);
    wr(fse_pkg::REG_CTRL, 32'h0000_0000);
    idle;
    wl;
    fr(40'h00_0000_0060, 8);
    fr(40'h00_0000_0075, 8);
    repeat (12) @(posedge clk);
    chk(32'(op_in_progress), 1);
    idle;
    rdchk(fse_pkg::REG_STAT, 32'h0000_0000);
    $display("suspend test done");
  endtask
  task automatic t_psusp;
    clr;
    wl;
    fr(40'h02_0400_00A5, 40);
    fr(40'h00_0000_0075, 8);
    repeat (12) @(posedge clk);
    rdchk(fse_pkg::REG_STAT, 32'h0000_0010);
    wl;
    fr(40'h00_D850_0000, 32);
    fr(40'h02_0500_005A, 40);
    chk({go_n[15:0], ref_n[15:0]}, 32'h0000_0002);
    fr(40'h00_0000_007A, 8);
    chk(32'(op_in_progress), 1);
    idle;
    rdchk(fse_pkg::REG_STAT, 32'h0000_0002);
    fr(40'h00_0000_0004, 8);
    $display("program suspend test done");
  endtask
  // ----------------------------------------------------------------
  // Clock, monitor, main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Counts array and command pulses; cuts a hang short
  always @(posedge clk) begin
    cyc++;
    go_n += int'(arr_erase_go === 1'b1);
    ref_n += int'(cmd_refused === 1'b1);
    ok_n += int'(cmd_ok === 1'b1);
    if (arr_erase_go === 1'b1) begin
      blk_r = arr_erase_blk;
      all_r = arr_erase_all;
    end
    if (cyc == 40000) begin
      err_count++;
      finish_test;
    end
  end
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, q_r} = {3'h4, 40'h0, 1'b0};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_erase;
    t_prot;
    t_susp;
    t_psusp;
    finish_test;
  end
endmodule
